// ---- include/dsc_pkg.sv ----
`default_nettype none
package dsc_pkg;
    localparam int CLK_PERIOD_NS  = 4;
    // Conversion clock tick, one count of the counter
    localparam int TICK_NS        = 400;
    localparam int TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
    localparam int TRIG_PULSE_NS  = 150;
    localparam int TRIG_PULSE_CYC = TRIG_PULSE_NS / CLK_PERIOD_NS;
    localparam int TRIG_HZ_8      = 3200;
    localparam int TRIG_HZ_10     = 800;
    localparam int TRIG_HZ_12     = 200;
    localparam int CONV_MAX_NS_8  = 314000;
    localparam int CONV_MAX_NS_10 = 1240000;
    localparam int CONV_MAX_NS_12 = 4900000;
    localparam int BCD_FS         = 2000;
    localparam int OUT_W          = 13;
    localparam int CNT_W          = 14;
    localparam int TKC_W          = 8;
    localparam int TRC_W          = 24;
    localparam int IRQ_W          = 3;
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_OVR        = 1;
    localparam int IRQ_ABORT      = 2;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_RESULT   = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN   = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h14;

    function automatic int trig_cyc(input int bits);
        int hz;
        hz = (bits <= 8) ? TRIG_HZ_8 : (bits <= 10) ? TRIG_HZ_10 : TRIG_HZ_12;
        return 1000000000 / (hz * CLK_PERIOD_NS);
    endfunction

    function automatic int conv_max_cyc(input int bits);
        int ns;
        ns = (bits <= 8) ? CONV_MAX_NS_8 : (bits <= 10) ? CONV_MAX_NS_10 : CONV_MAX_NS_12;
        return ns / CLK_PERIOD_NS;
    endfunction

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_INTEG  = 2'b01,
        ST_ENCODE = 2'b11
    } dsc_state_e;

    typedef struct packed {
        logic             sign;
        logic             ovr;
        logic [OUT_W-1:0] mag;
    } dsc_result_s;

    typedef struct packed {
        logic             neg;
        logic [CNT_W-1:0] mag;
    } dsc_ain_s;

    typedef struct packed {
        dsc_state_e       st;
        logic [TKC_W-1:0] tick_cnt;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] amp;
        dsc_result_s      res;
        logic             eoc;
        logic             start_d;
        logic             bcd;
        logic             cbcd;
        logic [TRC_W-1:0] trig_cnt;
        logic             trig_out;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic             irq;
        logic             hready;
        logic             hresp;
        logic [31:0]      hrdata;
        logic             wr_pend;
        logic [7:0]       wr_addr;
    } dsc_regs_s;

    localparam dsc_regs_s RST_S = '{st: ST_IDLE, hready: 1'b1, default: '0};
endpackage
`default_nettype wire

// ---- hdl/dsc_conv.sv ----
// Notes on behaviour
// - Start rising edge clears counter, restarts conversion
// - End-of-conversion high while busy, low after
// - Result stable from done until next start
// - Sign one for positive, zero for negative
// - Overrange one when magnitude exceeds full scale
// - Sign-magnitude binary or 3.5 digit BCD
// - Integration lasts one fixed counter ramp
// - Encoding counts from zero to acquired value
// - Conversion time within per-width maximum for binary; BCD fits only the 12-bit limit
// - Trigger output pulse starts a conversion
// - Trigger self-starts at maximum conversion rate
// - Strap disables trigger, output held low
`timescale 1ns/1ps
`default_nettype none
module dsc_conv #(
    parameter int MAG_BITS        = 12,
    parameter int TICK_CYC        = dsc_pkg::TICK_CYC,
    parameter int TRIG_PERIOD_CYC = dsc_pkg::trig_cyc(MAG_BITS),
    parameter int CONV_MAX_CYC    = dsc_pkg::conv_max_cyc(MAG_BITS)
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                start_conv,
    input  wire logic                trig_off,
    input  wire dsc_pkg::dsc_ain_s   ain,
    output logic                     eoc,
    output dsc_pkg::dsc_result_s     result,
    output logic                     trig_out,
    output logic                     irq,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata
);
    dsc_pkg::dsc_regs_s              s;
    dsc_pkg::dsc_regs_s              next_s;
    logic                            start_rise;
    logic                            tick;
    logic [dsc_pkg::CNT_W-1:0]       fs_m1;
    logic [dsc_pkg::IRQ_W-1:0]       ev;
    logic [dsc_pkg::IRQ_W-1:0]       clr;
    logic [31:0]                     rd;
    int                              hc;

    function automatic logic [dsc_pkg::OUT_W-1:0] bcd_inc(
        input logic [dsc_pkg::OUT_W-1:0] v
    );
        logic [dsc_pkg::OUT_W-1:0] r;
        logic                      c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            if (c)
            begin
                if (r[i*4 +: 4] == 4'h9)
                begin
                    r[i*4 +: 4] = 4'h0;
                end
                else
                begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        if (c)
        begin
            r[12] = 1'b1;
        end
        return r;
    endfunction

    always_comb
    begin
        next_s = s;
        ev = '0;
        clr = '0;
        rd = '0;
        start_rise = start_conv & ~s.start_d;
        // Full scale latched per conversion so a mode write cannot bend it
        fs_m1 = s.cbcd ? dsc_pkg::CNT_W'(dsc_pkg::BCD_FS - 1)
                       : dsc_pkg::CNT_W'((1 << MAG_BITS) - 1);
        tick = (s.tick_cnt == dsc_pkg::TKC_W'(TICK_CYC - 1));
        next_s.start_d = start_conv;
        next_s.tick_cnt = (tick || s.st == dsc_pkg::ST_IDLE) ? '0
                        : s.tick_cnt + 1'b1;
        unique case (s.st)
            dsc_pkg::ST_IDLE:
            begin
                next_s.st = dsc_pkg::ST_IDLE;
            end
            dsc_pkg::ST_INTEG:
            begin
                if (tick)
                begin
                    if (s.cnt == fs_m1)
                    begin
                        next_s.st = dsc_pkg::ST_ENCODE;
                        next_s.cnt = '0;
                        next_s.amp = ain.mag;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 1'b1;
                    end
                end
            end
            dsc_pkg::ST_ENCODE:
            begin
                if (tick)
                begin
                    if (s.cnt == s.amp || s.cnt == fs_m1)
                    begin
                        next_s.st = dsc_pkg::ST_IDLE;
                        next_s.eoc = 1'b0;
                        next_s.res.ovr = (s.amp > fs_m1);
                        ev[dsc_pkg::IRQ_DONE] = 1'b1;
                        ev[dsc_pkg::IRQ_OVR] = (s.amp > fs_m1);
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 1'b1;
                        next_s.res.mag = s.cbcd ? bcd_inc(s.res.mag)
                                       : s.res.mag + 1'b1;
                    end
                end
            end
            default:
            begin
                next_s.st = dsc_pkg::ST_IDLE;
            end
        endcase
        // Start wins over a finishing step in the same cycle, though the done and overrange flags of that step still set
        if (start_rise)
        begin
            ev[dsc_pkg::IRQ_ABORT] = s.eoc;
            next_s.st = dsc_pkg::ST_INTEG;
            next_s.cnt = '0;
            next_s.tick_cnt = '0;
            next_s.res = '0;
            next_s.res.sign = ~ain.neg;
            next_s.eoc = 1'b1;
            next_s.cbcd = s.bcd;
        end
        // Trigger free-runs only while the strap is open
        if (trig_off)
        begin
            next_s.trig_cnt = '0;
            next_s.trig_out = 1'b0;
        end
        else
        begin
            next_s.trig_cnt = (s.trig_cnt == dsc_pkg::TRC_W'(TRIG_PERIOD_CYC - 1))
                            ? '0 : s.trig_cnt + 1'b1;
            next_s.trig_out = (next_s.trig_cnt
                            < dsc_pkg::TRC_W'(dsc_pkg::TRIG_PULSE_CYC));
        end
        next_s.wr_pend = 1'b0;
        if (s.wr_pend)
        begin
            unique case (s.wr_addr)
                dsc_pkg::REG_CTRL:
                begin
                    next_s.bcd = hwdata[0];
                end
                dsc_pkg::REG_IRQ_EN:
                begin
                    next_s.irq_en = hwdata[dsc_pkg::IRQ_W-1:0];
                end
                dsc_pkg::REG_IRQ_CLR:
                begin
                    clr = hwdata[dsc_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    clr = '0;
                end
            endcase
        end
        // Set beats clear so no event is lost
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);
        unique case (haddr[7:0])
            dsc_pkg::REG_CTRL:     rd = {31'h0, s.bcd};
            dsc_pkg::REG_STATUS:   rd = {27'h0, s.cbcd, s.st, s.trig_out, s.eoc};
            dsc_pkg::REG_RESULT:   rd = {17'h0, s.res};
            dsc_pkg::REG_IRQ_STAT: rd = {29'h0, s.irq_stat};
            dsc_pkg::REG_IRQ_EN:   rd = {29'h0, s.irq_en};
            default:               rd = '0;
        endcase
        if (hsel && htrans[1] && hready)
        begin
            if (hwrite)
            begin
                next_s.wr_pend = 1'b1;
                next_s.wr_addr = haddr[7:0];
            end
            else
            begin
                next_s.hrdata = rd;
            end
        end
        // Zero wait states, always OKAY
        next_s.hready = 1'b1;
        next_s.hresp = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= dsc_pkg::RST_S;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign eoc       = s.eoc;
    assign result    = s.res;
    assign trig_out  = s.trig_out;
    assign irq       = s.irq;
    assign hreadyout = s.hready;
    assign hresp     = s.hresp;
    assign hrdata    = s.hrdata;

    // Cycles since the last start edge, counted only while busy
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hc <= 0;
        end
        else if (start_rise)
        begin
            hc <= 1;
        end
        else if (s.eoc)
        begin
            hc <= hc + 1;
        end
    end

    a_start_clears: assert property (@(posedge ref_clk) disable iff (rst)
        start_rise |=> s.res.mag == '0 && !s.res.ovr && s.cnt == '0 && s.eoc)
        else $error("start did not clear the counter");

    a_eoc_busy: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st != dsc_pkg::ST_IDLE) == s.eoc)
        else $error("end of conversion disagrees with state");

    a_result_stable: assert property (@(posedge ref_clk) disable iff (rst)
        (!s.eoc && !start_rise) |=> $stable(s.res))
        else $error("result moved while valid");

    a_sign_polar: assert property (@(posedge ref_clk) disable iff (rst)
        start_rise |=> s.res.sign == !$past(ain.neg))
        else $error("sign polarity wrong");

    a_ovr_flag: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s.eoc) |-> s.res.ovr == (s.amp > fs_m1)
                      && s.cnt == (s.res.ovr ? fs_m1 : s.amp))
        else $error("overrange or end count wrong");

    a_bcd_digits: assert property (@(posedge ref_clk) disable iff (rst)
        s.cbcd |-> s.res.mag[3:0] <= 4'h9 && s.res.mag[7:4] <= 4'h9
                && s.res.mag[11:8] <= 4'h9)
        else $error("bad BCD digit");

    a_integ_len: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == dsc_pkg::ST_ENCODE && $past(s.st) == dsc_pkg::ST_INTEG)
        |-> hc == (int'(fs_m1) + 1) * TICK_CYC + 1)
        else $error("integration length wrong");

    a_enc_len: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s.eoc) |-> hc == (int'(fs_m1) + int'(s.cnt) + 2) * TICK_CYC + 1)
        else $error("encoding length wrong");

    a_conv_max: assert property (@(posedge ref_clk) disable iff (rst)
        s.eoc |-> hc <= CONV_MAX_CYC)
        else $error("conversion overran its limit");

    a_trig_strap: assert property (@(posedge ref_clk) disable iff (rst)
        trig_off |=> !s.trig_out && s.trig_cnt == '0)
        else $error("trigger ran while strapped off");

    a_abort_restart: assert property (@(posedge ref_clk) disable iff (rst)
        (start_rise && s.eoc) |=> s.eoc && s.st == dsc_pkg::ST_INTEG
                                && s.irq_stat[dsc_pkg::IRQ_ABORT])
        else $error("abort did not restart");

    a_done_flag: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s.eoc) |-> s.irq_stat[dsc_pkg::IRQ_DONE])
        else $error("done flag not set at end of conversion");

    a_eoc_low_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (!s.eoc && !start_rise) |=> !s.eoc)
        else $error("end of conversion rose without a start");

    a_enc_from_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == dsc_pkg::ST_ENCODE && $past(s.st) == dsc_pkg::ST_INTEG)
        |-> s.cnt == '0 && s.res.mag == '0)
        else $error("encoding did not start from zero");

    a_enc_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == dsc_pkg::ST_ENCODE && !s.cbcd) |-> dsc_pkg::CNT_W'(s.res.mag) == s.cnt)
        else $error("binary result does not follow the counter");

    a_ovr_clip: assert property (@(posedge ref_clk) disable iff (rst)
        (!s.eoc && s.res.ovr) |-> s.res.mag == (s.cbcd ? 13'h1999 : dsc_pkg::OUT_W'(fs_m1)))
        else $error("overrange result not clipped to full scale");

    a_sign_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (s.eoc && !start_rise) |=> $stable(s.res.sign))
        else $error("sign moved during conversion");

    a_mode_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !start_rise |=> $stable(s.cbcd))
        else $error("coding mode changed without a start");

    a_tick_range: assert property (@(posedge ref_clk) disable iff (rst)
        s.tick_cnt < dsc_pkg::TKC_W'(TICK_CYC))
        else $error("tick divider out of range");

    a_trig_shape: assert property (@(posedge ref_clk) disable iff (rst)
        (!$past(trig_off) && !$past(rst))
        |-> s.trig_out == (s.trig_cnt < dsc_pkg::TRC_W'(dsc_pkg::TRIG_PULSE_CYC)))
        else $error("trigger pulse shape wrong");

    a_trig_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        s.trig_cnt <= dsc_pkg::TRC_W'(TRIG_PERIOD_CYC - 1))
        else $error("trigger counter passed its period");
endmodule // dsc_conv
`default_nettype wire

// ---- verification/dsc_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl_model #(
    parameter int PULSE_CYC = 37
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 go,
    input  wire logic                 eoc,
    input  wire dsc_pkg::dsc_result_s result,
    output logic                      start_conv,
    output dsc_pkg::dsc_result_s      cap,
    output int                        cap_cyc,
    output logic                      cap_valid
);
    int   width;
    int   cnt;
    logic eoc_q;

    always @(posedge ref_clk)
    begin
        eoc_q     <= eoc;
        cnt       <= cnt + 1;
        cap_valid <= 1'b0;
        if (rst)
        begin
            start_conv <= 1'b0;
            width      <= 0;
        end
        else if (go)
        begin
            // Short pulse keeps the integration period accurate
            start_conv <= 1'b1;
            width      <= PULSE_CYC;
            cnt        <= 0;
        end
        else if (width > 1)
            width <= width - 1;
        else
            start_conv <= 1'b0;
        if (!rst && eoc_q && !eoc)
        begin
            cap       <= result;
            cap_cyc   <= cnt;
            cap_valid <= 1'b1;
        end
    end
endmodule // dsc_ctrl_model
`default_nettype wire

// ---- verification/dsc_conv_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_conv_tb;
    localparam int TK = 2;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 trig_off = 1'b1;
    logic                 self_trig = 1'b0;
    logic                 go = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = '0;
    logic [1:0]           htrans = '0;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = '0;
    dsc_pkg::dsc_ain_s    ain = '0;
    logic                 eoc, trig_out, irq, hreadyout, hresp, start_m, cap_valid;
    logic [31:0]          hrdata;
    dsc_pkg::dsc_result_s result, cap;
    int                   cap_cyc, n, m;
    int                   mismatches = 0;
    int                   cmp_count = 0;
    int                   cyc = 0;
    wire                  start_conv = start_m | (self_trig & trig_out);

    initial forever #2 ref_clk = ~ref_clk;

    dsc_conv #(.MAG_BITS(8), .TICK_CYC(TK), .TRIG_PERIOD_CYC(300), .CONV_MAX_CYC(8100))
    dsc_conv_inst (.ref_clk(ref_clk), .rst(rst), .start_conv(start_conv),
        .trig_off(trig_off), .ain(ain), .eoc(eoc), .result(result), .trig_out(trig_out),
        .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));

    dsc_ctrl_model dsc_ctrl_model_inst (.ref_clk(ref_clk), .rst(rst), .go(go), .eoc(eoc),
        .result(result), .start_conv(start_m), .cap(cap), .cap_cyc(cap_cyc),
        .cap_valid(cap_valid));

    task stop_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk("register read", exp, q);
    endtask

    task conv(input logic bcd, input logic neg, input int mag, input logic abort);
        int         fs;
        int         lim;
        logic [12:0] em;
        fs  = bcd ? 2000 : 256;
        lim = (mag > fs - 1) ? fs - 1 : mag;
        em  = bcd ? {lim >= 1000, 4'((lim % 1000) / 100), 4'((lim % 100) / 10), 4'(lim % 10)}
                  : 13'(lim);
        wr(dsc_pkg::REG_CTRL, {31'h0, bcd});
        ain <= '{neg: neg, mag: 14'(mag)};
        repeat (abort ? 2 : 1)
        begin
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (60) @(posedge ref_clk);
            chk("busy", {16'h0, 1'b1, ~neg, 14'h0}, {16'h0, eoc, result});
        end
        do @(posedge ref_clk); while (cap_valid !== 1'b1);
        chk("conv time", (fs + lim + 1) * TK + 1, cap_cyc);
        chk("result", {17'h0, ~neg, mag > fs - 1, em}, 32'(cap));
        repeat (50) @(posedge ref_clk);
        chk("held", {16'h0, 1'b0, cap}, {16'h0, eoc, result});
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("reset", 32'h4, 32'({eoc, irq, hreadyout, hresp, trig_out}));
        rd(dsc_pkg::REG_STATUS, 32'h0);
        self_trig <= 1'b1;
        trig_off  <= 1'b0;
        do @(posedge ref_clk); while (trig_out !== 1'b1);
        // First pulse runs one short, counter leaves reset at one
        do @(posedge ref_clk); while (trig_out === 1'b1);
        do @(posedge ref_clk); while (trig_out !== 1'b1);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (trig_out === 1'b1);
        m = n;
        do begin @(posedge ref_clk); m++; end while (trig_out !== 1'b1);
        chk("trig width", 32'd37, n);
        chk("trig period", 32'd300, m);
        chk("self start", 32'h1, 32'(eoc));
        trig_off  <= 1'b1;
        self_trig <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("trig off", 32'h0, 32'(trig_out));
        conv(1'b0, 1'b0, 0, 1'b0);
        conv(1'b0, 1'b1, 0, 1'b0);
        conv(1'b0, 1'b0, 128, 1'b0);
        conv(1'b0, 1'b1, 255, 1'b0);
        conv(1'b1, 1'b0, 1234, 1'b0);
        conv(1'b1, 1'b1, 2500, 1'b0);
        wr(dsc_pkg::REG_IRQ_CLR, 32'h7);
        wr(dsc_pkg::REG_IRQ_EN, 32'h1);
        conv(1'b0, 1'b0, 300, 1'b1);
        repeat (2) @(posedge ref_clk);
        chk("irq on", 32'h1, 32'(irq));
        rd(dsc_pkg::REG_IRQ_STAT, 32'h7);
        rd(dsc_pkg::REG_RESULT, 32'h60ff);
        rd(8'h18, 32'h0);
        wr(dsc_pkg::REG_IRQ_EN, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", 32'h0, 32'(irq));
        wr(dsc_pkg::REG_IRQ_EN, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk("irq ovr", 32'h1, 32'(irq));
        wr(dsc_pkg::REG_IRQ_CLR, 32'h7);
        repeat (2) @(posedge ref_clk);
        chk("irq clr", 32'h0, 32'(irq));
        rd(dsc_pkg::REG_IRQ_STAT, 32'h0);
        stop_test();
    end
endmodule // dsc_conv_tb
`default_nettype wire
